// ### hdl/scl_regs.sv
// serial loopback and calibration control/status register bank
// assumes a plain register port on mclk, status pins from other domains,
// and tx/rx parallel data on mclk
`timescale 1ns/1ps
module scl_regs #(
	parameter int                DATA_W       = 10,
	parameter int                CODE_W       = 6,
	parameter logic [CODE_W-1:0] DEFAULT_CODE = '0,
	parameter int                WDOG_CYC_0   = scl_pkg::WDOG_CYC_0,
	parameter int                WDOG_CYC_1   = scl_pkg::WDOG_CYC_1,
	parameter int                WDOG_CYC_2   = scl_pkg::WDOG_CYC_2,
	parameter int                WDOG_CYC_3   = scl_pkg::WDOG_CYC_3
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// register port
	input  wire logic [11:0]       reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	// parallel serial-block data
	input  wire logic [DATA_W-1:0] tx_data,
	input  wire logic [DATA_W-1:0] rx_pin_data,
	output logic      [DATA_W-1:0] tx_pin_q,
	output logic      [DATA_W-1:0] rx_data_q,
	// status pins from the analog side
	input  wire logic              recovery_lock_flag,
	input  wire logic              data_sync_flag,
	// comparator offset tuning engine
	input  wire logic              step_done,
	input  wire logic [CODE_W-1:0] step_code,
	output logic                   cal_step_q,
	output logic      [CODE_W-1:0] cal_code_q,
	output logic                   cal_busy_q,
	output logic                   cal_abort_q,
	output logic      [3:0]        force_en_q
);

	localparam int SW = CODE_W + 3;
	localparam int AW = CODE_W + 3;

	// ==========================================================
	// elaboration checks
	if (DATA_W < 1 || CODE_W < 1) begin : g_bad_width
		$error("scl_regs: widths must be at least one");
	end
	if (WDOG_CYC_0 < 2 || WDOG_CYC_1 < 2 || WDOG_CYC_2 < 2 ||
	    WDOG_CYC_3 < 2 || WDOG_CYC_3 > 65535) begin : g_bad_wdog
		$error("scl_regs: watchdog counts must lie in 2..65535");
	end

	typedef enum logic [1:0] {S_IDLE, S_STEP, S_WAIT} scl_state_e;

	// ==========================================================
	// decoders shared by logic and checks
	function automatic logic [15:0] wdog_limit(input logic [1:0] sel);
		logic [15:0] lim;
		lim = 16'(WDOG_CYC_0);
		unique case (sel)
			2'h0: lim = 16'(WDOG_CYC_0);
			2'h1: lim = 16'(WDOG_CYC_1);
			2'h2: lim = 16'(WDOG_CYC_2);
			2'h3: lim = 16'(WDOG_CYC_3);
		endcase
		return lim;
	endfunction

	function automatic logic [3:0] avg_reps(input logic [1:0] sel);
		return 4'h1 << sel;
	endfunction

	// ==========================================================
	// status synchronisers
	logic [SW-1:0]     sync_d;
	logic [SW-1:0]     sync_q;
	logic              lock_s;
	logic              dsync_s;
	logic              done_s;
	logic [CODE_W-1:0] code_s;

	assign sync_d = {recovery_lock_flag, data_sync_flag, step_done,
	                 step_code};
	assign {lock_s, dsync_s, done_s, code_s} = sync_q;

	scl_sync #(
		.W (SW)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    (sync_d),
		.q    (sync_q)
	);

	// ==========================================================
	// register decode
	logic wr_loop;
	logic wr_cal;

	assign wr_loop = reg_wr && reg_addr == scl_pkg::LOOP_OFS;
	assign wr_cal  = reg_wr && reg_addr == scl_pkg::CAL_OFS;

	// reserved bits of this register are plain storage
	logic [15:0] loop_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			loop_q <= scl_pkg::LOOP_RST;
		end else if (wr_loop) begin
			loop_q <= reg_wdata;
		end
	end

	logic       wd_dis_q;
	logic [1:0] wd_sel_q;
	logic [1:0] avg_sel_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wd_dis_q   <= scl_pkg::CAL_RST[scl_pkg::WDOG_DIS_BIT];
			wd_sel_q   <= scl_pkg::CAL_RST[scl_pkg::WDOG_SEL_LSB +: 2];
			avg_sel_q  <= scl_pkg::CAL_RST[scl_pkg::AVG_LSB +: 2];
			force_en_q <= scl_pkg::CAL_RST[scl_pkg::FORCE_LSB +:
			                               scl_pkg::FORCE_W];
		end else if (wr_cal) begin
			wd_dis_q   <= reg_wdata[scl_pkg::WDOG_DIS_BIT];
			wd_sel_q   <= reg_wdata[scl_pkg::WDOG_SEL_LSB +: 2];
			avg_sel_q  <= reg_wdata[scl_pkg::AVG_LSB +: 2];
			force_en_q <= reg_wdata[scl_pkg::FORCE_LSB +:
			                        scl_pkg::FORCE_W];
		end
	end

	logic start_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			start_q <= scl_pkg::CAL_RST[scl_pkg::START_BIT];
		end else begin
			start_q <= wr_cal && reg_wdata[scl_pkg::START_BIT];
		end
	end

	// ==========================================================
	// read path
	logic [15:0] cal_word;

	always_comb begin
		cal_word = '0;
		cal_word[scl_pkg::WDOG_DIS_BIT] = wd_dis_q;
		cal_word[scl_pkg::WDOG_SEL_LSB +: 2] = wd_sel_q;
		cal_word[scl_pkg::AVG_LSB +: 2] = avg_sel_q;
		cal_word[scl_pkg::START_BIT] = start_q;
		cal_word[scl_pkg::LOCK_BIT] = lock_s;
		cal_word[scl_pkg::FORCE_LSB +: scl_pkg::FORCE_W] = force_en_q;
		cal_word[scl_pkg::SYNC_BIT] = dsync_s;
	end

	// data stands one cycle only so stale reads cannot be mistaken
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				scl_pkg::LOOP_OFS: reg_rdata <= loop_q;
				scl_pkg::CAL_OFS:  reg_rdata <= cal_word;
				default:           reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================================
	// loopback datapath
	// turn tx back before the io cells
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_pin_q  <= '0;
			rx_data_q <= '0;
		end else begin
			tx_pin_q  <= tx_data;
			rx_data_q <= loop_q[scl_pkg::LOOP_EN_BIT] ? tx_data
			                                          : rx_pin_data;
		end
	end

	// ==========================================================
	// calibration sequencer
	scl_state_e        state_q;
	logic [15:0]       wd_cnt_q;
	logic [1:0]        run_sel_q;
	logic [1:0]        run_avg_q;
	logic [3:0]        rep_q;
	logic [AW-1:0]     acc_q;
	logic              done_prev_q;
	logic              busy;
	logic              done_rise;
	logic              tmo;
	logic              last_rep;
	logic [AW-1:0]     acc_next;
	logic [CODE_W-1:0] avg_d;

	assign busy      = state_q != S_IDLE;
	assign done_rise = done_s && !done_prev_q;
	assign tmo       = busy && !wd_dis_q &&
	                   wd_cnt_q == wdog_limit(run_sel_q) - 16'h1;
	assign last_rep  = rep_q + 4'h1 == avg_reps(run_avg_q);
	assign acc_next  = acc_q + AW'(code_s);
	assign avg_d     = CODE_W'(acc_next >> run_avg_q);

	always_ff @(posedge mclk) begin
		if (rst) begin
			done_prev_q <= 1'b0;
		end else begin
			done_prev_q <= done_s;
		end
	end

	// count up to the selected abort time
	always_ff @(posedge mclk) begin
		if (rst) begin
			wd_cnt_q <= '0;
		end else if (!busy || wd_dis_q) begin
			wd_cnt_q <= '0;
		end else begin
			wd_cnt_q <= wd_cnt_q + 16'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q     <= S_IDLE;
			run_sel_q   <= '0;
			run_avg_q   <= '0;
			rep_q       <= '0;
			acc_q       <= '0;
			cal_step_q  <= 1'b0;
			cal_code_q  <= DEFAULT_CODE;
			cal_busy_q  <= 1'b0;
			cal_abort_q <= 1'b0;
		end else begin
			cal_step_q <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					if (start_q) begin
						state_q    <= S_STEP;
						run_sel_q  <= wd_sel_q;
						run_avg_q  <= avg_sel_q;
						rep_q      <= '0;
						acc_q      <= '0;
						cal_busy_q <= 1'b1;
					end
				end
				S_STEP: begin
					if (tmo) begin
						state_q     <= S_IDLE;
						cal_code_q  <= DEFAULT_CODE;
						cal_abort_q <= 1'b1;
						cal_busy_q  <= 1'b0;
					end else begin
						state_q    <= S_WAIT;
						cal_step_q <= 1'b1;
					end
				end
				S_WAIT: begin
					// late calibration falls back to default
					if (tmo) begin
						state_q     <= S_IDLE;
						cal_code_q  <= DEFAULT_CODE;
						cal_abort_q <= 1'b1;
						cal_busy_q  <= 1'b0;
					end else if (done_rise) begin
						acc_q <= acc_next;
						rep_q <= rep_q + 4'h1;
						if (last_rep) begin
							state_q     <= S_IDLE;
							cal_code_q  <= avg_d;
							cal_abort_q <= 1'b0;
							cal_busy_q  <= 1'b0;
						end else begin
							state_q <= S_STEP;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic [15:0] rd_cal_q;
	logic        rd_cal_hit_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_cal_q     <= '0;
			rd_cal_hit_q <= 1'b0;
		end else begin
			rd_cal_q     <= cal_word;
			rd_cal_hit_q <= reg_rd && reg_addr == scl_pkg::CAL_OFS;
		end
	end

	chk_loop_route: assert property (
		loop_q[scl_pkg::LOOP_EN_BIT] |=>
		rx_data_q == $past(tx_data))
		else $error("loopback data not routed to rx");

	chk_wdog_abort: assert property (
		(state_q == S_WAIT && tmo) |=>
		(state_q == S_IDLE && cal_code_q == DEFAULT_CODE &&
		 cal_abort_q && !cal_busy_q))
		else $error("watchdog expiry did not apply default");

	chk_wdog_off: assert property (
		(busy && wd_dis_q) |=> !cal_abort_q || $past(cal_abort_q))
		else $error("abort raised while watchdog disabled");

	chk_wdog_bound: assert property (
		busy |-> wd_cnt_q < wdog_limit(run_sel_q))
		else $error("watchdog count passed the selected limit");

	chk_avg_count: assert property (
		(state_q == S_WAIT && done_rise && !tmo && last_rep) |->
		rep_q == avg_reps(run_avg_q) - 4'h1 ##1 state_q == S_IDLE)
		else $error("run count differs from averaging code");

	chk_start_run: assert property (
		(wr_cal && reg_wdata[scl_pkg::START_BIT] && !busy) |=>
		start_q ##1 (cal_busy_q && state_q == S_STEP))
		else $error("start command did not launch a run");

	chk_start_clear: assert property (
		start_q |-> $past(wr_cal && reg_wdata[scl_pkg::START_BIT]))
		else $error("start bit held without a write");

	chk_lock_read: assert property (
		rd_cal_hit_q |->
		reg_rdata[scl_pkg::LOCK_BIT] == rd_cal_q[scl_pkg::LOCK_BIT] &&
		rd_cal_q[scl_pkg::LOCK_BIT] == $past(lock_s))
		else $error("lock bit read differs from lock status");

	chk_reset_zero: assert property (
		$fell(rst) |-> cal_word == 16'h0000)
		else $error("calibration register not zero after reset");

	chk_full_apply: assert property (
		(state_q == S_WAIT && wd_dis_q && done_rise && last_rep) |=>
		cal_code_q == $past(avg_d) && !cal_abort_q)
		else $error("finished run did not apply the average");

	cov_loop_on: cover property (
		loop_q[scl_pkg::LOOP_EN_BIT] ##1 reg_rd);
	cov_abort: cover property (
		state_q == S_WAIT && tmo);
	cov_eight_runs: cover property (
		state_q == S_WAIT && done_rise && last_rep && run_avg_q == 2'h3);

endmodule

// ### hdl/scl_pkg.sv
// register map, field layout and timing constants for the serial
// loopback and calibration register bank
// assumes one 100 MHz device clock shared by every user of the package
package scl_pkg;

	// ==========================================================
	// register offsets and reset values
	localparam logic [11:0] LOOP_OFS = 12'h42c;
	localparam logic [11:0] CAL_OFS  = 12'h42e;
	localparam logic [15:0] LOOP_RST = 16'h0000;
	localparam logic [15:0] CAL_RST  = 16'h0000;

	// ==========================================================
	// field positions
	localparam int LOOP_EN_BIT  = 4;
	localparam int WDOG_DIS_BIT = 11;
	localparam int WDOG_SEL_LSB = 9;
	localparam int AVG_LSB      = 7;
	localparam int START_BIT    = 6;
	localparam int LOCK_BIT     = 5;
	localparam int FORCE_LSB    = 1;
	localparam int FORCE_W      = 4;
	localparam int SYNC_BIT     = 0;

	// ==========================================================
	// watchdog times
	localparam int CLK_MHZ    = 100;
	localparam int WDOG_US_0  = 32;
	localparam int WDOG_US_1  = 48;
	localparam int WDOG_US_2  = 64;
	localparam int WDOG_US_3  = 128;
	localparam int WDOG_CYC_0 = WDOG_US_0 * CLK_MHZ;
	localparam int WDOG_CYC_1 = WDOG_US_1 * CLK_MHZ;
	localparam int WDOG_CYC_2 = WDOG_US_2 * CLK_MHZ;
	localparam int WDOG_CYC_3 = WDOG_US_3 * CLK_MHZ;

endpackage

// ### hdl/scl_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes multi-bit groups are held stable while they are sampled
`timescale 1ns/1ps
module scl_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ### test/scl_regs_tb.sv
// self-checking bench for the serial loopback and calibration registers
// assumes scl_regs on a 100 MHz mclk, watchdog counts cut to 20/30/40/80
`timescale 1ns/1ps
module scl_regs_tb;

	// ==========================================================
	// stimulus and observed signals
	logic        mclk               = 1'b0;
	logic        rst                = 1'b1;
	logic [11:0] reg_addr           = 12'h000;
	logic [15:0] reg_wdata          = 16'h0000;
	logic        reg_wr             = 1'b0;
	logic        reg_rd             = 1'b0;
	logic [15:0] reg_rdata;
	logic [9:0]  tx_data            = 10'h000;
	logic [9:0]  rx_pin_data        = 10'h000;
	logic [9:0]  tx_pin_q;
	logic [9:0]  rx_data_q;
	logic        recovery_lock_flag = 1'b0;
	logic        data_sync_flag     = 1'b0;
	logic        step_done          = 1'b0;
	logic [5:0]  step_code          = 6'h00;
	logic        cal_step_q;
	logic [5:0]  cal_code_q;
	logic        cal_busy_q;
	logic        cal_abort_q;
	logic [3:0]  force_en_q;
	int          n_errors           = 0;
	int          samples_checked    = 0;
	int          lim [4]            = '{20, 30, 40, 80};

	always #5 mclk = ~mclk;

	scl_regs #(
		.WDOG_CYC_0(20),
		.WDOG_CYC_1(30),
		.WDOG_CYC_2(40),
		.WDOG_CYC_3(80)
	) scl_regs_inst (
		.mclk              (mclk),
		.rst               (rst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.tx_data           (tx_data),
		.rx_pin_data       (rx_pin_data),
		.tx_pin_q          (tx_pin_q),
		.rx_data_q         (rx_data_q),
		.recovery_lock_flag(recovery_lock_flag),
		.data_sync_flag    (data_sync_flag),
		.step_done         (step_done),
		.step_code         (step_code),
		.cal_step_q        (cal_step_q),
		.cal_code_q        (cal_code_q),
		.cal_busy_q        (cal_busy_q),
		.cal_abort_q       (cal_abort_q),
		.force_en_q        (force_en_q)
	);

	// ==========================================================
	// shared helpers
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// settle past the edge before looking
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask

	task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [11:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// one tuning run: wait for the step pulse, answer after a delay
	task automatic serve(input logic [5:0] code, input int delay);
		int n;
		n = 0;
		do begin
			tick;
			n++;
		end while (cal_step_q !== 1'b1 && n < 300);
		check("step pulse", 16'(cal_step_q), 16'h0001);
		repeat (delay) tick;
		@(posedge mclk);
		step_code <= code;
		step_done <= 1'b1;
		// short hold so the next step pulse lands after this task returns
		repeat (2) @(posedge mclk);
		step_done <= 1'b0;
	endtask

	// ==========================================================
	// scenarios
	task automatic test_reset;
		logic [15:0] v;
		reg_read(scl_pkg::LOOP_OFS, v);
		check("loop reset", v, scl_pkg::LOOP_RST);
		reg_read(scl_pkg::CAL_OFS, v);
		check("cal reset", v, scl_pkg::CAL_RST);
		check("force reset", 16'(force_en_q), 16'h0000);
	endtask

	task automatic test_regs;
		logic [15:0] v;
		// start bit left clear so no sequence launches
		reg_write(scl_pkg::CAL_OFS, 16'hffbf);
		reg_read(scl_pkg::CAL_OFS, v);
		check("cal readback", v, 16'h0f9e);
		check("force bits", 16'(force_en_q), 16'h000f);
		reg_write(scl_pkg::CAL_OFS, 16'h0000);
		reg_write(12'h42d, 16'hffff);
		reg_read(12'h42d, v);
		check("unmapped read", v, 16'h0000);
	endtask

	task automatic test_loop;
		logic [15:0] v;
		reg_write(scl_pkg::LOOP_OFS, 16'h0010);
		@(posedge mclk);
		tx_data <= 10'h2a5;
		rx_pin_data <= 10'h15a;
		tick;
		check("looped rx", 16'(rx_data_q), 16'h02a5);
		check("tx pins", 16'(tx_pin_q), 16'h02a5);
		reg_write(scl_pkg::LOOP_OFS, 16'hffef);
		reg_read(scl_pkg::LOOP_OFS, v);
		check("loop readback", v, 16'hffef);
		check("pin rx", 16'(rx_data_q), 16'h015a);
	endtask

	task automatic test_status;
		logic [15:0] v;
		@(posedge mclk);
		recovery_lock_flag <= 1'b1;
		data_sync_flag <= 1'b1;
		repeat (4) tick;
		reg_read(scl_pkg::CAL_OFS, v);
		check("status set", v, 16'h0021);
		recovery_lock_flag <= 1'b0;
		data_sync_flag <= 1'b0;
		repeat (4) tick;
		reg_read(scl_pkg::CAL_OFS, v);
		check("status clear", v, 16'h0000);
	endtask

	// watchdog off and code 0 latched: first run outlasts 20 cycles
	task automatic test_avg;
		int         sum;
		logic [5:0] c;
		for (int a = 0; a < 4; a++) begin
			sum = 0;
			reg_write(scl_pkg::CAL_OFS, 16'h0840 | 16'(a << 7));
			for (int i = 0; i < (1 << a); i++) begin
				c = 6'(10 + 3 * i);
				sum += c;
				serve(c, (i == 0) ? 100 : 3);
			end
			repeat (6) tick;
			check("avg busy", 16'(cal_busy_q), 16'h0000);
			check("avg code", 16'(cal_code_q), 16'(sum >> a));
			check("avg abort", 16'(cal_abort_q), 16'h0000);
		end
	endtask

	task automatic test_wdog;
		int          n;
		logic [15:0] v;
		for (int k = 0; k < 4; k++) begin
			reg_write(scl_pkg::CAL_OFS, 16'(k << 9) | 16'h0040);
			n = 0;
			while (cal_busy_q !== 1'b1 && n < 10) begin
				tick;
				n++;
			end
			n = 0;
			while (cal_busy_q === 1'b1 && n < 200) begin
				n++;
				tick;
			end
			check("wdog span", 16'(n), 16'(lim[k]));
			check("abort flag", 16'(cal_abort_q), 16'h0001);
			check("default code", 16'(cal_code_q), 16'h0000);
			reg_read(scl_pkg::CAL_OFS, v);
			check("start cleared", v, 16'(k << 9));
		end
	endtask

	// ==========================================================
	// run control
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		test_reset;
		test_regs;
		test_loop;
		test_status;
		test_avg;
		test_wdog;
		report_and_stop;
	end

	// whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		report_and_stop;
	end

endmodule
